// file: hw/mmr_fifo.sv
`timescale 1ns/100ps
module mmr_fifo #(
    parameter int W = 9,
    parameter int D = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wptr_reg;
    logic [AW:0]  rptr_reg;
    logic         full;
    logic         empty;

    assign full      = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
    assign empty     = wptr_reg == rptr_reg;
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rptr_reg[AW-1:0]];

    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem[wptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            if (in_valid && !full) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (out_ready && !empty) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
        end
    end
endmodule

// file: hw/mmr_router.sv
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "mmr_map.svh"
module mmr_router import mmr_pkg::*; #(
    parameter logic [23:0] MAKER_ID = 24'h5a_a5_3c  // Arbitrary value
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Inbound byte streams: 0 physical, 1 foot_controller_port, 2 host
    input  wire logic [2:0]        rx_valid,
    input  wire logic [2:0][7:0]   rx_data,
    output logic [2:0]             rx_ready,
    // Own outbound messages
    input  wire logic              int_valid,
    input  wire mmr_byte_s         int_byte,
    input  wire mmr_kind_e         int_kind,
    output logic                   int_ready,
    // Physical output
    output logic                   phys_tx_valid,
    output mmr_byte_s              phys_tx,
    input  wire logic              phys_tx_ready,
    // Host output
    output logic                   usb_tx_valid,
    output mmr_byte_s              usb_tx,
    input  wire logic              usb_tx_ready,
    // Foot controller output
    output logic                   foot_tx_valid,
    output mmr_byte_s              foot_tx,
    input  wire logic              foot_tx_ready,
    // Preset selection and remote controller values
    output logic                   preset_load,
    output logic [8:0]             preset_index,
    output logic [9:0]             preset_shown,
    output logic [11:0][6:0]       remote_value
);
    function automatic logic [1:0] msg_len(input logic [7:0] st);
        logic [1:0] n;
        n = 2'd1;
        case (st[7:4])
            4'hc, 4'hd: n = 2'd2;
            4'h8, 4'h9, 4'ha, 4'hb, 4'he: n = 2'd3;
            4'hf: n = (st == 8'hf2) ? 2'd3 : ((st == 8'hf1 || st == 8'hf3) ? 2'd2 : 2'd1);
            default: n = 2'd1;
        endcase
        return n;
    endfunction

    mmr_ctrl_s   ctrl_reg;
    logic [7:0]  bias_reg;
    logic [11:0] rdef_reg;
    logic [8:0]  map_mem [`MMR_MAP_SIZE];
    logic [31:0] prdata_reg;
    logic [31:0] rd_next;
    logic        map_hit;
    logic        hit;

    logic [3:0]  src_v;
    logic [3:0]  src_rdy;
    mmr_byte_s   src_b [4];
    mmr_arb_e    arb_reg;
    logic [1:0]  owner_reg;
    logic [1:0]  ptr_reg;
    logic [1:0]  pick;
    logic [1:0]  idx;
    logic        found;
    logic [1:0]  gnt;
    logic        gv;
    mmr_byte_s   ab;
    logic        to_phys;
    logic        to_usb;
    logic        to_foot;
    logic        gated;
    logic        arb_rdy;
    logic        fire;
    logic        fifo_in_v;
    logic        fifo_in_rdy;

    logic [7:0]  st_reg;
    logic [6:0]  d1_reg;
    logic        core_ev;
    logic        chan_ok;
    logic        pc_pend_reg;
    logic [8:0]  pc_sum_reg;
    logic        pc_go_reg;
    logic [8:0]  pc_sum2_reg;
    logic [8:0]  map_q_reg;
    logic [8:0]  target;

    // Register file
    assign map_hit = paddr[11:9] == `MMR_MAP_BASE && paddr[1:0] == 2'b00;
    assign hit     = map_hit || paddr == `MMR_OFF_CTRL || paddr == `MMR_OFF_BIAS
                     || paddr == `MMR_OFF_REMOTE || paddr == `MMR_OFF_STATUS
                     || paddr == `MMR_OFF_ID;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata  = prdata_reg;

    always_comb begin
        rd_next = 32'h0;
        if (map_hit) begin
            rd_next = {23'h0, map_mem[paddr[`MMR_MAP_MSB:`MMR_MAP_LSB]]};
        end else begin
            case (paddr)
                `MMR_OFF_CTRL:   rd_next = {19'h0, ctrl_reg};
                `MMR_OFF_BIAS:   rd_next = {24'h0, bias_reg};
                `MMR_OFF_REMOTE: rd_next = {20'h0, rdef_reg};
                `MMR_OFF_STATUS: rd_next = {12'h0, preset_shown, 1'b0, preset_index};
                `MMR_OFF_ID:     rd_next = {8'h0, MAKER_ID};
                default:         rd_next = 32'h0;
            endcase
        end
    end

    // Read data latched in setup so access needs no wait state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata_reg <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= rd_next;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= mmr_ctrl_s'(`MMR_CTRL_RST);
            bias_reg <= `MMR_BIAS_RST;
            rdef_reg <= `MMR_REMOTE_RST;
        end else if (psel && penable && pwrite) begin
            case (paddr)
                `MMR_OFF_CTRL:   ctrl_reg <= mmr_ctrl_s'(pwdata[`MMR_CTRL_W-1:0]);
                `MMR_OFF_BIAS:   bias_reg <= pwdata[7:0];
                `MMR_OFF_REMOTE: rdef_reg <= pwdata[11:0];
                default:         ;
            endcase
        end
    end

    // Map table; identifier has no write path at all
    always_ff @(posedge clk) begin
        if (psel && penable && pwrite && map_hit) begin
            map_mem[paddr[`MMR_MAP_MSB:`MMR_MAP_LSB]] <= pwdata[8:0];
        end
    end

    // Per-source framing, restores status bytes dropped by running status
    for (genvar gi = 0; gi < 3; gi++) begin : g_frm
        logic [7:0] rs_reg;
        logic [1:0] pos_reg;
        logic [1:0] len_reg;
        logic       sx_reg;
        logic [7:0] ib;
        logic [7:0] ob;
        logic       rt;
        logic       need_st;
        logic       stray;
        logic       lst;

        always_comb begin
            ib      = rx_data[gi];
            rt      = ib >= 8'hf8;
            need_st = !ib[7] && !sx_reg && pos_reg == 2'd0 && rs_reg[7];
            stray   = !ib[7] && !sx_reg && pos_reg == 2'd0 && !rs_reg[7];
            ob      = need_st ? rs_reg : ib;
            if (rt) begin
                lst = pos_reg == 2'd0 && !sx_reg;
            end else if (ob[7]) begin
                lst = ob != 8'hf0 && msg_len(ob) == 2'd1;
            end else begin
                lst = !sx_reg && (pos_reg + 2'd1 == len_reg);
            end
        end

        // Orphan data bytes are swallowed, never forwarded
        assign src_v[gi]    = rx_valid[gi] && !stray;
        assign src_b[gi]    = '{data: ob, last: lst};
        assign rx_ready[gi] = stray || (src_rdy[gi] && !need_st);

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                rs_reg  <= 8'h00;
                pos_reg <= 2'd0;
                len_reg <= 2'd1;
                sx_reg  <= 1'b0;
            end else if (src_v[gi] && src_rdy[gi] && !rt) begin
                if (ob[7]) begin
                    rs_reg  <= (ob < 8'hf0) ? ob : 8'h00;
                    len_reg <= msg_len(ob);
                    pos_reg <= lst ? 2'd0 : 2'd1;
                    sx_reg  <= ob == 8'hf0;
                end else if (!sx_reg) begin
                    pos_reg <= lst ? 2'd0 : pos_reg + 2'd1;
                end
            end
        end
    end

    assign src_v[3]  = int_valid;
    assign src_b[3]  = int_byte;
    assign int_ready = src_rdy[3];

    // Round-robin message arbiter
    always_comb begin
        pick  = ptr_reg;
        found = 1'b0;
        idx   = ptr_reg;
        for (int k = 0; k < 4; k++) begin
            idx = ptr_reg + 2'(k);
            if (!found && src_v[idx]) begin
                pick  = idx;
                found = 1'b1;
            end
        end
    end

    assign gnt = (arb_reg == ARB_LOCK) ? owner_reg : pick;
    assign gv  = (arb_reg == ARB_LOCK) ? src_v[owner_reg] : found;
    assign ab  = src_b[gnt];

    always_comb begin
        gated = (int_kind == MMR_KIND_TUNER && ctrl_reg.rtgate != MMR_RT_ALL
                 && ctrl_reg.rtgate != MMR_RT_TUNER)
             || (int_kind == MMR_KIND_TEMPO && ctrl_reg.rtgate != MMR_RT_ALL
                 && ctrl_reg.rtgate != MMR_RT_TEMPO);
        case (gnt)
            2'd0, 2'd1: to_phys = ctrl_reg.thru;
            2'd2:       to_phys = ctrl_reg.bridge;
            default:    to_phys = !gated;
        endcase
        to_usb  = ctrl_reg.bridge && gnt < 2'd2;
        to_foot = ctrl_reg.bridge && gnt == 2'd2;
    end

    // All destinations take a byte together, so a stalled host or foot port, or a full physical FIFO, stalls the source
    assign arb_rdy       = (!to_phys || fifo_in_rdy) && (!to_usb || usb_tx_ready)
                           && (!to_foot || foot_tx_ready);
    assign fire          = gv && arb_rdy;
    assign fifo_in_v     = fire && to_phys;
    assign usb_tx_valid  = fire && to_usb;
    assign foot_tx_valid = fire && to_foot;
    assign usb_tx        = ab;
    assign foot_tx       = ab;

    for (genvar gs = 0; gs < 4; gs++) begin : g_rdy
        assign src_rdy[gs] = gv && gnt == 2'(gs) && arb_rdy;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            arb_reg   <= ARB_IDLE;
            owner_reg <= 2'd0;
            ptr_reg   <= 2'd0;
        end else if (fire) begin
            owner_reg <= gnt;
            case (arb_reg)
                ARB_IDLE: arb_reg <= ab.last ? ARB_IDLE : ARB_LOCK;
                ARB_LOCK: arb_reg <= ab.last ? ARB_IDLE : ARB_LOCK;
                default:  arb_reg <= ARB_IDLE;
            endcase
            if (ab.last) begin
                ptr_reg <= gnt + 2'd1;
            end
        end
    end

    mmr_fifo #(
        .W ($bits(mmr_byte_s)),
        .D (`MMR_FIFO_DEPTH)
    ) u_phys_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (fifo_in_v),
        .in_ready  (fifo_in_rdy),
        .in_data   (ab),
        .out_valid (phys_tx_valid),
        .out_ready (phys_tx_ready),
        .out_data  (phys_tx)
    );

    // Inbound decoding; every inbound source is always consumed
    assign core_ev = fire && gnt != 2'd3 && ab.last && !ab.data[7];
    assign chan_ok = ctrl_reg.omni || st_reg[3:0] == ctrl_reg.chan;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= 8'h00;
            d1_reg <= 7'h00;
        end else if (fire && gnt != 2'd3) begin
            if (ab.data[7]) begin
                if (ab.data < 8'hf8) begin
                    st_reg <= ab.data;
                end
            end else begin
                d1_reg <= ab.data[6:0];
            end
        end
    end

    // Bias, then registered map read, then range and repeat checks
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_pend_reg <= 1'b0;
            pc_sum_reg  <= 9'd0;
            pc_go_reg   <= 1'b0;
            pc_sum2_reg <= 9'd0;
            map_q_reg   <= 9'd0;
        end else begin
            pc_pend_reg <= core_ev && st_reg[7:4] == 4'hc && chan_ok
                           && ctrl_reg.pcen;
            if (core_ev) begin
                pc_sum_reg <= {2'b00, ab.data[6:0]} + {1'b0, bias_reg};
            end
            map_q_reg   <= map_mem[pc_sum_reg[6:0]];
            pc_go_reg   <= pc_pend_reg;
            pc_sum2_reg <= pc_sum_reg;
        end
    end

    assign target = (ctrl_reg.custom && pc_sum2_reg < 9'd128) ? map_q_reg
                                                              : pc_sum2_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            preset_load  <= 1'b0;
            preset_index <= 9'd0;
        end else begin
            preset_load <= 1'b0;
            if (pc_go_reg && target <= `MMR_MAX_PRESET
                && !(ctrl_reg.filter && target == preset_index)) begin
                preset_load  <= 1'b1;
                preset_index <= target;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            preset_shown <= 10'd0;
        end else begin
            preset_shown <= {1'b0, preset_index} + {9'd0, ctrl_reg.dispoff};
        end
    end

    for (genvar gc = 0; gc < `MMR_NUM_CTRL; gc++) begin : g_ctl
        logic       seen_reg;
        logic [6:0] val_reg;

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                seen_reg <= 1'b0;
                val_reg  <= 7'h00;
            end else if (core_ev && st_reg[7:4] == 4'hb && chan_ok
                         && d1_reg == `MMR_CC_BASE + 7'(gc)) begin
                seen_reg <= 1'b1;
                val_reg  <= ab.data[6:0];
            end else if (!seen_reg) begin
                val_reg <= rdef_reg[gc] ? 7'h7f : 7'h00;
            end
        end

        // Local flops keep each controller value to a single driving process
        assign remote_value[gc] = val_reg;
    end

    default clocking cb_clk @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_chan_gate;
        core_ev && st_reg[7:4] == 4'hc && !chan_ok |=> !pc_pend_reg;
    endproperty
    a_chan_gate: assert property (p_chan_gate) else $error("off-channel program change taken");

    property p_thru_copy;
        fire && gnt == 2'd0 && ctrl_reg.thru |-> fifo_in_v;
    endproperty
    a_thru_copy: assert property (p_thru_copy) else $error("thru byte not copied");

    property p_pc_off;
        !ctrl_reg.pcen ##1 !ctrl_reg.pcen |-> ##1 !pc_pend_reg;
    endproperty
    a_pc_off: assert property (p_pc_off) else $error("program change taken while disabled");

    property p_identity;
        pc_go_reg && !ctrl_reg.custom && !ctrl_reg.filter |=> preset_load
            && preset_index == $past(pc_sum2_reg);
    endproperty
    a_identity: assert property (p_identity) else $error("unmapped preset not selected");

    property p_repeat_filter;
        preset_load && ctrl_reg.filter |-> preset_index != $past(preset_index);
    endproperty
    a_repeat_filter: assert property (p_repeat_filter) else $error("repeat request reloaded");

    property p_no_bridge;
        !ctrl_reg.bridge |-> !usb_tx_valid && !foot_tx_valid;
    endproperty
    a_no_bridge: assert property (p_no_bridge) else $error("forwarding with bridge off");

    property p_host_fwd;
        fire && gnt == 2'd2 && ctrl_reg.bridge |-> fifo_in_v && foot_tx_valid;
    endproperty
    a_host_fwd: assert property (p_host_fwd) else $error("host byte not forwarded");

    property p_rt_gate;
        fire && gnt == 2'd3 && int_kind != MMR_KIND_NORMAL
            && ctrl_reg.rtgate == MMR_RT_NONE |-> !fifo_in_v;
    endproperty
    a_rt_gate: assert property (p_rt_gate) else $error("gated realtime message emitted");

    property p_bias;
        core_ev |=> pc_sum_reg == {2'b00, $past(ab.data[6:0])} + {1'b0, $past(bias_reg)};
    endproperty
    a_bias: assert property (p_bias) else $error("bias not added");

    property p_range;
        preset_load |-> preset_index <= `MMR_MAX_PRESET;
    endproperty
    a_range: assert property (p_range) else $error("preset out of range");

    property p_no_interleave;
        fire && !ab.last |=> arb_reg == ARB_LOCK && gnt == $past(gnt);
    endproperty
    a_no_interleave: assert property (p_no_interleave) else $error("message interleaved");

    c_load: cover property (pc_go_reg ##1 preset_load);
    c_host: cover property (usb_tx_valid && usb_tx.last);
    c_sysex: cover property (fire && ab.data == 8'hf0 ##[1:20] fire && ab.data == 8'hf7);
endmodule

// file: shared/mmr_map.svh
`ifndef MMR_MAP_SVH
`define MMR_MAP_SVH

// Register byte offsets
`define MMR_OFF_CTRL     12'h000
`define MMR_OFF_BIAS     12'h004
`define MMR_OFF_REMOTE   12'h008
`define MMR_OFF_STATUS   12'h00c
`define MMR_OFF_ID       12'h010
`define MMR_MAP_BASE     3'h1
`define MMR_MAP_LSB      2
`define MMR_MAP_MSB      8

// Reset values: omni, preset select on, realtime gate all
`define MMR_CTRL_RST     13'h0850
`define MMR_BIAS_RST     8'h00
`define MMR_REMOTE_RST   12'h000

// Field positions
`define MMR_STAT_SHOWN   10
`define MMR_CTRL_W       13

// Limits and counts
`define MMR_MAX_PRESET   9'd383
`define MMR_MAP_SIZE     128
`define MMR_NUM_CTRL     12
`define MMR_CC_BASE      7'h10
`define MMR_FIFO_DEPTH   8

`endif

// file: shared/mmr_pkg.sv
package mmr_pkg;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } mmr_byte_s;

    typedef enum logic [1:0] {
        MMR_RT_NONE,
        MMR_RT_ALL,
        MMR_RT_TUNER,
        MMR_RT_TEMPO
    } mmr_rtgate_e;

    typedef enum logic [1:0] {
        MMR_KIND_NORMAL,
        MMR_KIND_TUNER,
        MMR_KIND_TEMPO
    } mmr_kind_e;

    typedef enum logic {
        ARB_IDLE,
        ARB_LOCK
    } mmr_arb_e;

    typedef struct packed {
        mmr_rtgate_e rtgate;
        logic        dispoff;
        logic        bridge;
        logic        filter;
        logic        custom;
        logic        pcen;
        logic        thru;
        logic        omni;
        logic [3:0]  chan;
    } mmr_ctrl_s;

endpackage

// file: test/mmr_far_end.sv
`timescale 1ns/100ps
module mmr_far_end import mmr_pkg::*; (
    // Clock, reset, stall request
    input  wire logic      clk,
    input  wire logic      rstn,
    input  wire logic      slow,
    // Router outputs
    input  wire logic      phys_tx_valid,
    input  wire mmr_byte_s phys_tx,
    input  wire logic      usb_tx_valid,
    input  wire mmr_byte_s usb_tx,
    input  wire logic      foot_tx_valid,
    input  wire mmr_byte_s foot_tx,
    // Acceptance
    output logic           phys_tx_ready,
    output logic           usb_tx_ready,
    output logic           foot_tx_ready
);
    logic [7:0] phys_q[$];
    logic [7:0] usb_q[$];
    logic [7:0] foot_q[$];
    logic [2:0] take_reg;

    // Random refusals force the router to hold whole messages
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            take_reg <= 3'h7;
        end else begin
            take_reg <= slow ? 3'($urandom) : 3'h7;
        end
    end
    assign {foot_tx_ready, usb_tx_ready, phys_tx_ready} = take_reg;

    always @(posedge clk) begin
        if (phys_tx_valid && phys_tx_ready) phys_q.push_back(phys_tx.data);
        if (usb_tx_valid && usb_tx_ready) usb_q.push_back(usb_tx.data);
        if (foot_tx_valid && foot_tx_ready) foot_q.push_back(foot_tx.data);
    end
endmodule

// file: test/test_mmr_router.sv
`timescale 1ns/100ps
`include "mmr_map.svh"
module test_mmr_router import mmr_pkg::*; ;
    localparam logic [23:0] ID_VAL = 24'h3c_96_e1;  // Arbitrary value
    logic             clk, rstn, psel, penable, pwrite, pready, pslverr, se, slow, got;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata, rd;
    logic [2:0]       rx_valid, rx_ready;
    logic [2:0][7:0]  rx_data;
    logic             int_valid, int_ready, preset_load;
    mmr_byte_s        int_byte, phys_tx, usb_tx, foot_tx;
    mmr_kind_e        int_kind;
    logic             phys_tx_valid, phys_tx_ready, usb_tx_valid, usb_tx_ready;
    logic             foot_tx_valid, foot_tx_ready;
    logic [8:0]       preset_index;
    logic [9:0]       preset_shown;
    logic [11:0][6:0] remote_value;
    int               miscompares, n_compared, rb, rp;

    mmr_router #(.MAKER_ID(ID_VAL)) mmr_router_i (.clk, .rstn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_data, .rx_ready,
        .int_valid, .int_byte, .int_kind, .int_ready, .phys_tx_valid, .phys_tx,
        .phys_tx_ready, .usb_tx_valid, .usb_tx, .usb_tx_ready, .foot_tx_valid, .foot_tx,
        .foot_tx_ready, .preset_load, .preset_index, .preset_shown, .remote_value);
    mmr_far_end mmr_far_end_i (.clk, .rstn, .slow, .phys_tx_valid, .phys_tx, .usb_tx_valid,
        .usb_tx, .foot_tx_valid, .foot_tx, .phys_tx_ready, .usb_tx_ready, .foot_tx_ready);

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    task tally_and_finish;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task chk(string what, logic [31:0] exp, logic [31:0] seen);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task apb(logic wr, logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        for (int k = 0; k < 40; k++) begin
            @(posedge clk);
            if (pready === 1'b1) begin
                rd = prdata;
                se = pslverr;
                psel <= 0;
                penable <= 0;
                return;
            end
        end
        miscompares++;
        tally_and_finish;
    endtask

    // Source 3 stands for the internal stream
    task hold(int s);
        for (int k = 0; k < 40; k++) begin
            @(negedge clk);
            got = (s == 3) ? int_ready : rx_ready[s];
            @(posedge clk);
            if (got) return;
        end
        miscompares++;
        tally_and_finish;
    endtask

    task wait_load;
        got = 0;
        repeat (12) begin
            @(negedge clk);
            if (preset_load === 1'b1) got = 1;
        end
        @(posedge clk);
    endtask

    task send(int s, logic [39:0] m, int n);
        for (int i = 0; i < n; i++) begin
            rx_valid[s] <= 1;
            rx_data[s] <= m[39-8*i -: 8];
            hold(s);
        end
        rx_valid[s] <= 0;
        wait_load;
    endtask

    task pc(logic [3:0] ch, logic [6:0] num, logic el, logic [8:0] ei);
        send(0, {4'hc, ch, 1'b0, num, 24'h0}, 2);
        chk("preset_load", 32'(el), 32'(got));
        if (el) chk("preset_index", 32'(ei), 32'(preset_index));
    endtask

    task int_msg(mmr_kind_e k);
        for (int i = 0; i < 3; i++) begin
            int_valid <= 1;
            int_kind <= k;
            int_byte <= {8'(24'hf001f7 >> (16 - 8 * i)), i == 2};
            hold(3);
        end
        int_valid <= 0;
    endtask

    task drain(int n);
        for (int k = 0; k < 40 && mmr_far_end_i.phys_q.size() < n; k++) @(posedge clk);
    endtask

    function automatic logic [8:0] biased(int p, int b);
        return 9'(p + b);
    endfunction

    function automatic logic rt_pass(int g, int k);
        return g == 1 || (g == 2 && k == 1) || (g == 3 && k == 2);
    endfunction

    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata, rx_valid, rx_data, int_valid} = '0;
        int_byte = '0;
        int_kind = MMR_KIND_NORMAL;
        {slow, miscompares, n_compared} = '0;
        void'($urandom(23253));
        repeat (5) @(posedge clk);
        rstn <= 1;
        apb(0, `MMR_OFF_CTRL, 0);
        chk("ctrl reset", 32'h850, rd);
        apb(1, `MMR_OFF_ID, 0);
        apb(0, `MMR_OFF_ID, 0);
        chk("maker id", {8'h0, ID_VAL}, rd);
        apb(0, 12'h100, 0);
        chk("unmapped", 1, se);
        slow <= 1;
        for (int g = 0; g < 4; g++) begin
            apb(1, `MMR_OFF_CTRL, 32'h070 | (g << 11));
            for (int k = 1; k < 3; k++) begin
                mmr_far_end_i.phys_q.delete();
                int_msg(mmr_kind_e'(k));
                drain(3);
                chk("rt gate", rt_pass(g, k) ? 3 : 0, mmr_far_end_i.phys_q.size());
            end
        end
        mmr_far_end_i.phys_q.delete();
        pc(0, 5, 1, 5);
        drain(2);
        chk("thru pc", 8'hc0, mmr_far_end_i.phys_q[0]);
        chk("no bridge", 0, mmr_far_end_i.usb_q.size());
        apb(1, `MMR_OFF_BIAS, 200);
        apb(1, `MMR_OFF_CTRL, 32'h470);
        pc(0, 100, 1, 300);
        apb(0, `MMR_OFF_STATUS, 0);
        chk("shown", (301 << 10) | 300, rd);
        repeat (6) begin
            rb = $urandom_range(255);
            rp = $urandom_range(127);
            apb(1, `MMR_OFF_BIAS, rb);
            pc(0, rp[6:0], 1, biased(rp, rb));
        end
        apb(1, `MMR_OFF_BIAS, 0);
        apb(1, `MMR_OFF_CTRL, 32'h170);
        pc(0, 7, 1, 7);
        pc(0, 7, 0, 7);
        apb(1, `MMR_OFF_CTRL, 32'h070);
        pc(0, 7, 1, 7);
        apb(1, `MMR_OFF_CTRL, 32'h030);
        pc(0, 9, 0, 0);
        apb(1, `MMR_OFF_CTRL, 32'h062);
        pc(3, 11, 0, 0);
        pc(2, 11, 1, 11);
        apb(1, 12'h23c, 100);
        apb(1, 12'h250, 400);
        apb(1, 12'h3fc, 383);
        apb(0, 12'h23c, 0);
        chk("map entry", 100, rd);
        apb(1, `MMR_OFF_CTRL, 32'h0f0);
        pc(0, 15, 1, 100);
        pc(0, 20, 0, 0);
        pc(0, 127, 1, 383);
        apb(1, `MMR_OFF_CTRL, 32'h270);
        mmr_far_end_i.phys_q.delete();
        send(2, 40'h9040500000, 3);
        chk("host to foot", 3, mmr_far_end_i.foot_q.size());
        send(0, 40'h903c403e40, 5);
        drain(9);
        chk("phys to host", 6, mmr_far_end_i.usb_q.size());
        chk("merged", 9, mmr_far_end_i.phys_q.size());
        chk("status again", 8'h90, mmr_far_end_i.phys_q[6]);
        chk("host status", 8'h90, mmr_far_end_i.usb_q[3]);
        send(1, 40'hb011220000, 3);
        chk("remote set", 7'h22, remote_value[1]);
        chk("remote held", 0, remote_value[0]);
        apb(1, `MMR_OFF_REMOTE, 32'h006);
        apb(0, `MMR_OFF_REMOTE, 0);
        chk("remote reg", 32'h006, rd);
        chk("remote full", 7'h7f, remote_value[2]);
        chk("remote kept", 7'h22, remote_value[1]);
        chk("remote zero", 0, remote_value[0]);
        tally_and_finish;
    end
endmodule
